//--- src/btgbr_regs.svh
`ifndef BTGBR_REGS_SVH
`define BTGBR_REGS_SVH

// Opcode fields
`define OPC_TOGGLE 4'h7
`define OPC_BR_OV 8'hE4
`define OPC_BR_Z 8'hE0

// Field positions inside the 16-bit instruction word
`define F_OPC_HI 15
`define F_OPC_LO 12
`define F_BIT_HI 11
`define F_BIT_LO 9
`define F_ACC 8
`define F_ADDR_HI 7
`define F_ADDR_LO 0
`define F_UBYTE_HI 15
`define F_UBYTE_LO 8

// Access bank and indexed literal offset limits
`define ACC_LOW_LIMIT 8'h5F
`define ACC_HIGH_BANK 4'hF

// Quarter-cycle codes
`define Q1 2'h0
`define Q2 2'h1
`define Q3 2'h2
`define Q4 2'h3

// Reset values
`define DATA_RST 8'h00
`define INSTR_RST 16'h0000

`endif

//--- src/btgbr_pkg.sv
package btgbr_pkg;

	// Execution states, one-hot
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_KILL = 2'b10
	} exec_state_t;

	// Decoded operation kind
	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_TOGGLE = 2'h1,
		OP_BR_OV = 2'h2,
		OP_BR_Z = 2'h3
	} op_kind_t;

	// Data memory request toward the core's data memory
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// Program counter update toward the fetch path
	typedef struct packed {
		logic load;
		logic flush;
		logic [20:0] target;
	} pc_req_t;

endpackage

//--- src/q_phase_counter.sv
`include "btgbr_regs.svh"

// Splits the instruction clock into four quarters, Q1 to Q4
module q_phase_counter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	output logic [1:0] phase_o
);
	logic [1:0] phase_q;
	logic [1:0] phase_d;

	// Wraps Q4 back to Q1; frozen while the enable is low
	always_comb begin
		phase_d = phase_q;
		if (ce_i) begin
			phase_d = phase_q + 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= `Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase_o = phase_q;
endmodule // q_phase_counter

//--- src/bit_toggle_and_flag_branch_exec.sv
`include "btgbr_regs.svh"

// What this block does
// RULE1: The bit toggle op is one word: opcode 0111, 3-bit bit position, access bit, 8-bit address.
// RULE2: Bit toggle inverts only the chosen bit of the addressed register and touches no flag; the code flips it in the byte read at the previous address.
// RULE3: Access bit 0 selects the access bank, 1 lets the bank select register pick the bank.
// RULE4: Extended set on, access bit 0 and address up to 5Fh use indexed literal offset mode.
// RULE5: Bit toggle takes one cycle: decode Q1, read Q2, process Q3, write back Q4; the Q2 read goes out while MEM_ADDR_O still holds the previous address.
// RULE6: Branch on overflow is one word with upper byte E4h and a signed 8-bit offset.
// RULE7: With overflow set, the PC becomes the incremented address plus twice the offset.
// RULE8: The doubled offset is added to the already incremented PC, not the branch address.
// RULE9: A taken branch writes the PC in Q4 and then spends one whole cycle doing nothing.
// RULE10: An untaken branch takes one cycle and leaves the PC alone in Q4.
// RULE11: Branch on zero is one word with upper byte E0h and a signed 8-bit offset.
// RULE12: With the zero flag set, branch on zero jumps; otherwise it falls through.
// RULE13: Neither branch changes a flag, and the cycle after a taken branch drops the prefetch.
module bit_toggle_and_flag_branch_exec #(
	parameter int PC_W = 21,
	parameter int BANK_W = 4,
	parameter int ADDR_W = 12
) (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic [15:0] INSTR_I,
	input wire logic [PC_W-1:0] PC_I,
	input wire logic OV_FLAG_I,
	input wire logic Z_FLAG_I,
	input wire logic EXT_SET_EN_I,
	input wire logic [BANK_W-1:0] BANK_SELECT_REGISTER_I,
	input wire logic [ADDR_W-1:0] INDEX_BASE_I,
	input wire logic [7:0] MEM_RDATA_I,
	output logic [1:0] Q_PHASE_O,
	output logic MEM_RD_O,
	output logic MEM_WR_O,
	output logic [ADDR_W-1:0] MEM_ADDR_O,
	output logic [7:0] MEM_WDATA_O,
	output logic PC_LOAD_O,
	output logic [PC_W-1:0] PC_TARGET_O,
	output logic FLUSH_O
);
	// The structs carry fixed widths, so the parameters may not stray from them
	if (PC_W != 21 || ADDR_W != 12 || BANK_W + 8 != ADDR_W) begin : g_bad_width
		$error("Unsupported width parameters");
	end

	logic [1:0] phase;
	logic [1:0] phase_q;
	logic [1:0] phase_d;
	btgbr_pkg::exec_state_t state_q;
	btgbr_pkg::exec_state_t state_d;
	btgbr_pkg::op_kind_t op_q;
	btgbr_pkg::op_kind_t op_d;
	logic [15:0] instr_q;
	logic [15:0] instr_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic taken_q;
	logic taken_d;
	btgbr_pkg::mem_req_t mem_q;
	btgbr_pkg::mem_req_t mem_d;
	btgbr_pkg::pc_req_t pc_q;
	btgbr_pkg::pc_req_t pc_d;
	logic [ADDR_W-1:0] eff_addr;
	logic [7:0] reg_field;
	logic [2:0] bit_field;
	logic [7:0] bit_mask;
	logic [7:0] offs;
	logic [PC_W-1:0] offs2;

	q_phase_counter u_phase (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.phase_o(phase)
	);

	// Field extraction from the latched word
	assign reg_field = instr_q[`F_ADDR_HI:`F_ADDR_LO]; // [RULE1]
	assign bit_field = instr_q[`F_BIT_HI:`F_BIT_LO]; // [RULE1]
	assign offs = instr_q[`F_ADDR_HI:`F_ADDR_LO]; // [RULE6] [RULE11]
	assign bit_mask = 8'h01 << bit_field;

	// Doubled two's complement offset, sign-extended to the PC width
	assign offs2 = {{(PC_W - 9){offs[7]}}, offs, 1'b0}; // [RULE8]

	// Effective data address: indexed, access bank, or banked
	always_comb begin
		if (!instr_q[`F_ACC]) begin
			if (EXT_SET_EN_I && reg_field <= `ACC_LOW_LIMIT) begin
				eff_addr = INDEX_BASE_I + {{(ADDR_W - 8){1'b0}}, reg_field}; // [RULE4]
			end else if (reg_field <= `ACC_LOW_LIMIT) begin
				eff_addr = {{BANK_W{1'b0}}, reg_field}; // [RULE3]
			end else begin
				eff_addr = {`ACC_HIGH_BANK, reg_field}; // [RULE3]
			end
		end else begin
			eff_addr = {BANK_SELECT_REGISTER_I, reg_field}; // [RULE3]
		end
	end

	// Quarter-by-quarter sequencing; all state holds while the enable is low
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		instr_d = instr_q;
		data_d = data_q;
		taken_d = taken_q;
		mem_d = mem_q;
		pc_d = pc_q;
		if (CE_I) begin
			case (phase)
				`Q1: begin
					// Decode; during the dead cycle the prefetched word is ignored
					mem_d.wr = 1'b0;
					pc_d.load = 1'b0;
					if (state_q == btgbr_pkg::ST_KILL) begin
						op_d = btgbr_pkg::OP_NONE; // [RULE9] [RULE13]
						instr_d = `INSTR_RST;
					end else begin
						instr_d = INSTR_I;
						if (INSTR_I[`F_OPC_HI:`F_OPC_LO] == `OPC_TOGGLE) begin
							op_d = btgbr_pkg::OP_TOGGLE; // [RULE1]
						end else if (INSTR_I[`F_UBYTE_HI:`F_UBYTE_LO] == `OPC_BR_OV) begin
							op_d = btgbr_pkg::OP_BR_OV; // [RULE6]
						end else if (INSTR_I[`F_UBYTE_HI:`F_UBYTE_LO] == `OPC_BR_Z) begin
							op_d = btgbr_pkg::OP_BR_Z; // [RULE11]
						end else begin
							op_d = btgbr_pkg::OP_NONE;
						end
					end
					// Read request stands through Q2
					if (state_q != btgbr_pkg::ST_KILL &&
						INSTR_I[`F_OPC_HI:`F_OPC_LO] == `OPC_TOGGLE) begin
						mem_d.rd = 1'b1; // [RULE5]
					end
				end
				`Q2: begin
					// Register read (toggle) or flag sample (branch)
					mem_d.rd = 1'b0;
					if (op_q == btgbr_pkg::OP_TOGGLE) begin
						data_d = MEM_RDATA_I; // [RULE5]
						// Address latched here, so it reaches MEM_ADDR_O from Q3 on, after the read request has dropped, and holds for the write
						mem_d.addr = eff_addr; // [RULE3] [RULE4]
					end
					case (op_q)
						btgbr_pkg::OP_BR_OV: taken_d = OV_FLAG_I; // [RULE7]
						btgbr_pkg::OP_BR_Z: taken_d = Z_FLAG_I; // [RULE12]
						default: taken_d = 1'b0;
					endcase
				end
				`Q3: begin
					// Process data; results are registered to appear in Q4
					if (op_q == btgbr_pkg::OP_TOGGLE) begin
						mem_d.wdata = data_q ^ bit_mask; // [RULE2]
						mem_d.wr = 1'b1; // [RULE5]
					end
					if (taken_q) begin
						pc_d.target = PC_I + offs2; // [RULE7] [RULE8]
						pc_d.load = 1'b1; // [RULE9]
					end else begin
						pc_d.load = 1'b0; // [RULE10]
					end
				end
				`Q4: begin
					// Taken branch makes the next cycle a no-operation
					mem_d.wr = 1'b0;
					pc_d.load = 1'b0;
					if (taken_q) begin
						state_d = btgbr_pkg::ST_KILL; // [RULE9]
						pc_d.flush = 1'b1; // [RULE13]
					end else begin
						state_d = btgbr_pkg::ST_RUN; // [RULE10]
						pc_d.flush = 1'b0;
					end
					taken_d = 1'b0;
				end
				default: begin
					state_d = btgbr_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Reported phase moves only on enabled edges, so it stands still while frozen
	always_comb begin
		phase_d = phase_q;
		if (CE_I) begin
			phase_d = phase;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			state_q <= btgbr_pkg::ST_RUN;
			op_q <= btgbr_pkg::OP_NONE;
			instr_q <= `INSTR_RST;
			data_q <= `DATA_RST;
			taken_q <= 1'b0;
			mem_q <= '0;
			pc_q <= '0;
			phase_q <= `Q1;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			instr_q <= instr_d;
			data_q <= data_d;
			taken_q <= taken_d;
			mem_q <= mem_d;
			pc_q <= pc_d;
			phase_q <= phase_d;
		end
	end

	// Status flags are inputs only: this block has no path to change them
	assign Q_PHASE_O = phase_q;
	assign MEM_RD_O = mem_q.rd;
	assign MEM_WR_O = mem_q.wr;
	assign MEM_ADDR_O = mem_q.addr;
	assign MEM_WDATA_O = mem_q.wdata;
	assign PC_LOAD_O = pc_q.load;
	assign PC_TARGET_O = pc_q.target;
	assign FLUSH_O = pc_q.flush;
endmodule // bit_toggle_and_flag_branch_exec

//--- tb/btgbr_properties.sv
module btgbr_properties (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic [15:0] INSTR_I,
	input wire logic [20:0] PC_I,
	input wire logic OV_FLAG_I,
	input wire logic Z_FLAG_I,
	input wire logic [3:0] BANK_SELECT_REGISTER_I,
	input wire logic [7:0] MEM_RDATA_I,
	input wire logic [1:0] Q_PHASE_O,
	input wire logic MEM_RD_O,
	input wire logic MEM_WR_O,
	input wire logic [11:0] MEM_ADDR_O,
	input wire logic [7:0] MEM_WDATA_O,
	input wire logic PC_LOAD_O,
	input wire logic [20:0] PC_TARGET_O,
	input wire logic FLUSH_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// Toggle phases, data and address; inputs seen at the edges that sample them
	AST_RD_WR: assert property (MEM_RD_O |-> Q_PHASE_O == 2'h0 ##2 MEM_WR_O)
		else $error("toggle write phase wrong");
	AST_WDATA: assert property (MEM_WR_O |-> MEM_WDATA_O ==
		($past(MEM_RDATA_I, 2) ^ (8'h01 << $past(INSTR_I[11:9], 3))))
		else $error("toggle data wrong");
	AST_BANK: assert property (MEM_WR_O && $past(INSTR_I[8], 3) |->
		MEM_ADDR_O == {$past(BANK_SELECT_REGISTER_I, 2), $past(INSTR_I[7:0], 3)})
		else $error("banked address wrong");
	AST_TOG_RD: assert property (Q_PHASE_O == 2'h0 && !FLUSH_O &&
		$past(INSTR_I[15:12]) == 4'h7 |-> MEM_RD_O)
		else $error("toggle not decoded");
	// Branch decisions follow the flag sampled in Q2
	AST_OV: assert property (Q_PHASE_O == 2'h0 && !FLUSH_O &&
		$past(INSTR_I[15:8]) == 8'hE4 |-> ##2 PC_LOAD_O == $past(OV_FLAG_I, 2))
		else $error("overflow branch wrong");
	AST_Z: assert property (Q_PHASE_O == 2'h0 && !FLUSH_O &&
		$past(INSTR_I[15:8]) == 8'hE0 |-> ##2 PC_LOAD_O == $past(Z_FLAG_I, 2))
		else $error("zero branch wrong");
	AST_TGT: assert property (PC_LOAD_O |-> PC_TARGET_O == $past(PC_I) +
		21'($signed({$past(INSTR_I[7:0], 3), 1'b0})))
		else $error("branch target wrong");
	AST_FLUSH: assert property (PC_LOAD_O |=> FLUSH_O [*4] ##1 !FLUSH_O)
		else $error("flush length wrong");
	AST_QUIET: assert property (FLUSH_O |-> !MEM_RD_O && !PC_LOAD_O)
		else $error("activity in flushed cycle");
endmodule // btgbr_properties

bind bit_toggle_and_flag_branch_exec btgbr_properties btgbr_properties_i (.*);

//--- tb/btgbr_data_mem.sv
module btgbr_data_mem (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rd_val_i,
	output logic [7:0] rdata_o,
	output int n_wr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [4096];
	initial n_wr_o = 0;
	// Inverse outside a read, so a sample in the wrong phase shows up
	assign rdata_o = rd_i ? rd_val_i : ~rd_val_i;
	// Writes land at the edge that ends the write phase
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem[addr_i] <= wdata_i;
			n_wr_o <= n_wr_o + 1;
		end
	end
endmodule // btgbr_data_mem

//--- tb/bit_toggle_and_flag_branch_exec_tb.sv
module bit_toggle_and_flag_branch_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic CE_I = 1'b1;
	logic [15:0] INSTR_I = 16'h0000;
	logic [20:0] PC_I = 21'h0_0000;
	logic OV_FLAG_I = 1'b0;
	logic Z_FLAG_I = 1'b0;
	logic EXT_SET_EN_I = 1'b0;
	logic [3:0] BANK_SELECT_REGISTER_I = 4'h3;
	logic [11:0] INDEX_BASE_I = 12'h200;
	logic [7:0] MEM_RDATA_I, MEM_WDATA_O;
	logic [7:0] rd_val = 8'h00;
	logic [1:0] Q_PHASE_O;
	logic MEM_RD_O, MEM_WR_O, PC_LOAD_O, FLUSH_O;
	logic [11:0] MEM_ADDR_O;
	logic [20:0] PC_TARGET_O, last_target;
	int n_load = 0;
	int n_wr, k, w;
	int n_fail = 0;
	int checks_done = 0;

	always #5 MCLK_I = ~MCLK_I;

	bit_toggle_and_flag_branch_exec bit_toggle_and_flag_branch_exec_i (.*);
	btgbr_data_mem btgbr_data_mem_i (.clk_i(MCLK_I), .rd_i(MEM_RD_O), .wr_i(MEM_WR_O),
		.addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O), .rd_val_i(rd_val),
		.rdata_o(MEM_RDATA_I), .n_wr_o(n_wr));

	// Count program counter loads and keep the last target
	always @(posedge MCLK_I) begin
		if (PC_LOAD_O === 1'b1) begin
			n_load <= n_load + 1;
			last_target <= PC_TARGET_O;
		end
	end

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk_data(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_pc(input logic [20:0] got, input logic [20:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One word per instruction cycle; clearing after Q1 keeps it from being taken twice
	task issue(input logic [15:0] word);
		INSTR_I = word;
		@(posedge MCLK_I);
		#1 INSTR_I = 16'h0000;
		repeat (3) @(posedge MCLK_I);
		#1;
	endtask

	task do_toggle(input logic a, input logic [7:0] f, input logic [2:0] b,
		input logic ext, input logic [7:0] rd, input logic [11:0] ea);
		EXT_SET_EN_I = ext;
		rd_val = rd;
		issue({4'h7, b, a, f});
		chk_data(btgbr_data_mem_i.mem[ea], rd ^ (8'h01 << b));
	endtask

	// Every addressing path, edge bits, flags high that must not matter
	task test_toggle;
		OV_FLAG_I = 1'b1;
		Z_FLAG_I = 1'b1;
		k = n_load;
		do_toggle(1'b1, 8'h75, 3'h4, 1'b0, 8'h75, 12'h375);
		do_toggle(1'b0, 8'h5F, 3'h0, 1'b0, 8'h00, 12'h05F);
		do_toggle(1'b0, 8'h60, 3'h7, 1'b0, 8'hFF, 12'hF60);
		do_toggle(1'b0, 8'h5F, 3'h2, 1'b1, 8'hA5, 12'h25F);
		do_toggle(1'b0, 8'h61, 3'h5, 1'b1, 8'h3C, 12'hF61);
		chk_data(8'(n_load - k), 8'h00);
		$display("test_toggle done");
	endtask

	// Both branches taken and not, extreme offsets, a toggle right behind each
	task test_branch;
		for (int i = 0; i < 4; i++) begin
			k = n_load;
			w = n_wr;
			OV_FLAG_I = i[0] ^ i[1];
			Z_FLAG_I = ~(i[0] ^ i[1]);
			PC_I = 21'h0_1002;
			issue({i[1] ? 8'hE0 : 8'hE4, i[1] ? 8'h7F : 8'h80});
			chk_data(8'(n_load - k), {7'h00, i[0]});
			if (i[0])
				chk_pc(last_target, i[1] ? 21'h0_1100 : 21'h0_0F02);
			issue(16'h7E10);
			chk_data(8'(n_wr - w), {7'h00, ~i[0]});
		end
		$display("test_branch done");
	endtask

	// Enable low between instructions: phase stands, a word held meanwhile is taken once
	task test_freeze;
		w = n_wr;
		CE_I = 1'b0;
		INSTR_I = 16'h7E10;
		repeat (5) @(posedge MCLK_I);
		#1 chk_data({6'h00, Q_PHASE_O}, 8'h03);
		chk_data(8'(n_wr - w), 8'h00);
		CE_I = 1'b1;
		do_toggle(1'b0, 8'h10, 3'h7, 1'b0, 8'h0F, 12'h010);
		$display("test_freeze done");
	endtask

	initial begin
		repeat (8) @(posedge MCLK_I);
		#1 RST_I = 1'b0;
		k = 0;
		while (Q_PHASE_O !== 2'h3 && k < 9) begin
			@(posedge MCLK_I);
			#1 k++;
		end
		if (k == 9)
			n_fail++;
		if (k < 9) begin
			test_toggle;
			test_branch;
			test_freeze;
		end
		final_report;
	end
endmodule // bit_toggle_and_flag_branch_exec_tb
